// [bench/legacy_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Real legacy controller answering status and mask fetches.
// ****************************************************************
module legacy_ctrl_model #(
  parameter logic [7:0] STATUS_VAL = 8'hC3,
  parameter logic [7:0] MASK_VAL = 8'h3C
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fetch request and answer delay.
  input wire logic fetch_req,
  input wire logic fetch_is_mask,
  input wire logic [3:0] lag,
  // Answer.
  output logic fetch_ack,
  output logic [7:0] fetch_data
);
  logic [3:0] wait_cnt; // Cycles spent on this fetch.
  logic done; // Answered, waiting for the request to drop.
  // One answer per request; data flips outside it so no stale byte passes.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      done <= 1'b0;
      fetch_ack <= 1'b0;
      fetch_data <= 8'h00;
    end else begin
      fetch_ack <= 1'b0;
      fetch_data <= ~fetch_data;
      if (!fetch_req) begin
        wait_cnt <= 4'h0;
        done <= 1'b0;
      end else if (!done && wait_cnt == lag) begin
        fetch_ack <= 1'b1;
        fetch_data <= fetch_is_mask ? MASK_VAL : STATUS_VAL;
        done <= 1'b1;
      end else if (!done) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : legacy_ctrl_model
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "legacy_trap_map.svh"
module tb;
  import legacy_trap_pkg::*;
  // ****************************************************************
  // Signals.
  // ****************************************************************
  logic sys_clk, rst_n, reg_wr, reg_rd, pcpci_grant_n, global_trap_disable, legacy_audio_mode_bit;
  logic engine_mask_bit, ctrl_mask_wr, ctrl_mask_val, mode_mask_wr, mode_mask_val, legacy_engine_active;
  logic pcpci_xfer, pcpci_tc, pcpci_write, fetch_req, fetch_is_mask, fetch_ack;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] eng_cur_addr, eng_cur_count;
  logic [7:0] io_rdata, eng_page, eng_pcpci_data, fetch_data;
  logic [1:0] engine_status_reg, legacy_engine_sel;
  logic [3:0] lag; // Answer delay.
  io_cycle_t io_cyc;
  io_resp_t io_resp;
  eng_cmd_t eng_cmd;
  int bad_count = 0;
  int samples_checked = 0;
  legacy_io_trap_control i_legacy_io_trap_control (.sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .io_cyc, .pcpci_grant_n, .io_resp, .io_rdata, .global_trap_disable, .legacy_audio_mode_bit,
    .eng_cur_addr, .eng_cur_count, .eng_page, .eng_pcpci_data, .engine_status_reg, .engine_mask_bit, .eng_cmd,
    .ctrl_mask_wr, .ctrl_mask_val, .mode_mask_wr, .mode_mask_val, .legacy_engine_sel, .legacy_engine_active,
    .pcpci_xfer, .pcpci_tc, .pcpci_write, .fetch_req, .fetch_is_mask, .fetch_ack, .fetch_data);
  legacy_ctrl_model i_legacy_ctrl_model (.sys_clk, .rst_n, .fetch_req, .fetch_is_mask, .lag, .fetch_ack,
    .fetch_data);
  // 200 MHz clock.
  always #2.5 sys_clk = ~sys_clk;
  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  // Register write; ends on the edge that takes it.
  task automatic reg_wr_t(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t
  // Register read; data stands the cycle after.
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rchk
  // One host cycle; answers are checked while they stand.
  task automatic io_t(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_cyc <= '{valid: 1'b1, write: w, addr: a, data: d};
    @(posedge sys_clk);
    io_cyc <= '0;
    #1;
  endtask : io_t
  // Bounded wait for the fetch to finish.
  task automatic fetch_wait();
    int n = 0;
    while (fetch_req !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    chk("fetch_done", 32'h0, 32'(fetch_req));
    @(posedge sys_clk);
  endtask : fetch_wait
  task automatic pc_case(input logic [31:0] cfg, input logic w, input logic [15:0] a, input logic g,
                         input logic hit);
    reg_wr_t(12'h52C, cfg);
    pcpci_grant_n <= g;
    io_t(w, a, 8'h3C);
    chk("pcpci_claim", 32'({hit, hit}), 32'({io_resp.claim, pcpci_xfer}));
    if (hit) begin
      chk("pcpci_kind", 32'({a[2], w}), 32'({pcpci_tc, pcpci_write}));
      if (!w) begin
        chk("pcpci_data", 32'(eng_pcpci_data), 32'(io_rdata));
      end
    end
  endtask : pc_case
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_regs();
    chk("engine_sel_rst", 32'h0, 32'(legacy_engine_sel));
    rchk(12'h52C, `REG_RST, "pcpci_rst");
    rchk(12'h530, `REG_RST, "group_rst");
    rchk(12'h58C, `REG_RST, "global_rst");
    reg_wr_t(12'h52C, 32'hFFFF_FFFF);
    rchk(12'h52C, `PCP_WMASK, "pcpci_bits");
    reg_wr_t(12'h600, 32'hFFFF_FFFF);
    rchk(12'h600, 32'h0000_0000, "unmapped");
    reg_wr_t(12'h58C, 32'hFFFF_FFFF);
    legacy_audio_mode_bit <= 1'b1;
    rchk(12'h58C, `GCR_WMASK, "global_bits");
    chk("engine_active", 32'h1, 32'(legacy_engine_active));
    chk("engine_sel", 32'h3, 32'(legacy_engine_sel));
    reg_wr_t(12'h52C, `REG_RST);
    legacy_audio_mode_bit <= 1'b0;
  endtask : t_regs
  // Enable off, mode none, distributed mode, global disable: no snoop; then on.
  task automatic t_global();
    logic [31:0] cfg [4] = '{32'h0000_0D00, 32'h0000_0001, 32'h0000_0301, 32'h0000_0D01};
    reg_wr_t(12'h530, 32'h0020_0000);
    foreach (cfg[i]) begin
      reg_wr_t(12'h58C, cfg[i]);
      global_trap_disable <= (i == 3);
      io_t(1'b1, 16'h000C, 8'h00);
      chk("snoop_off", 32'h0, 32'(io_resp.snoop));
    end
    reg_wr_t(12'h58C, 32'h0000_0D01);
    global_trap_disable <= 1'b0;
    io_t(1'b1, 16'h000C, 8'h00);
    chk("snoop_on", 32'h1, 32'(io_resp.snoop));
  endtask : t_global
  // Engine 3: pointer toggles, clears, and holds across a page access.
  task automatic t_pointer();
    reg_wr_t(12'h530, 32'h8030_0000);
    io_t(1'b1, 16'h0000, 8'h11);
    chk("g2_wsnoop", 32'h1, 32'(io_resp.snoop));
    rchk(12'h530, 32'h8031_0000, "ptr_toggle");
    io_t(1'b1, 16'h000C, 8'h5A);
    rchk(12'h530, 32'h8030_0000, "ptr_clear");
    io_t(1'b0, 16'h0001, 8'h00);
    chk("g2_rsnoop", 32'h1, 32'(io_resp.snoop));
    io_t(1'b0, 16'h0006, 8'h00);
    chk("addr_hi", 32'({1'b1, eng_cur_addr[15:8]}), 32'({io_resp.claim, io_rdata}));
    io_t(1'b0, 16'h0082, 8'h00);
    chk("page", 32'({1'b1, eng_page}), 32'({io_resp.claim, io_rdata}));
    io_t(1'b0, 16'h0006, 8'h00);
    chk("addr_lo", 32'({1'b1, eng_cur_addr[7:0]}), 32'({io_resp.claim, io_rdata}));
    rchk(12'h530, 32'h8031_0000, "ptr_page");
  endtask : t_pointer
  task automatic t_group1_write();
    reg_wr_t(12'h530, 32'h2000_0000);
    io_t(1'b1, 16'h0007, 8'h5A);
    chk("ws_resp", 32'h1, 32'({io_resp.claim, io_resp.snoop}));
    chk("ws_cmd", 32'({1'b1, FLD_COUNT, 1'b0, 8'h5A}), 32'(eng_cmd));
    reg_wr_t(12'h530, 32'h4000_0000);
    io_t(1'b1, 16'h0082, 8'hA5);
    chk("wt_cmd", 32'({1'b1, 1'b1, FLD_PAGE, 1'b0, 8'hA5}), 32'({io_resp.claim, eng_cmd}));
  endtask : t_group1_write
  // Engine 2: shared mode and single mask writes.
  task automatic t_group3();
    reg_wr_t(12'h58C, 32'h0000_0901);
    reg_wr_t(12'h530, 32'h0100_0000);
    chk("engine_grouped", 32'h1, 32'(legacy_engine_active));
    io_t(1'b1, 16'h000B, 8'h46);
    chk("mode_cmd", 32'({1'b1, FLD_MODE, 8'h46}), 32'({eng_cmd.valid, eng_cmd.field, eng_cmd.data}));
    io_t(1'b1, 16'h000B, 8'h47);
    chk("mode_other", 32'h2, 32'({io_resp.snoop, eng_cmd.valid}));
    io_t(1'b1, 16'h000A, 8'h06);
    chk("smask_set", 32'h3, 32'({ctrl_mask_wr, ctrl_mask_val}));
    io_t(1'b1, 16'h000A, 8'h02);
    chk("smask_clr", 32'h2, 32'({ctrl_mask_wr, ctrl_mask_val}));
  endtask : t_group3
  // Retried status and mask reads, slow then prompt answers.
  task automatic t_group4();
    reg_wr_t(12'h530, 32'h01C0_0000);
    engine_status_reg <= 2'b01;
    lag <= 4'h3;
    io_t(1'b0, 16'h0008, 8'h00);
    chk("st_retry", 32'h6, 32'({io_resp.retry, fetch_req, fetch_is_mask}));
    io_t(1'b1, 16'h000B, 8'h46);
    chk("busy_cmd", 32'h1, 32'(eng_cmd.valid));
    fetch_wait();
    lag <= 4'h0;
    io_t(1'b0, 16'h0008, 8'h00);
    chk("st_data", 32'h0000_0187, 32'({io_resp.claim, io_rdata}));
    io_t(1'b0, 16'h000F, 8'h00);
    chk("mk_retry", 32'h1, 32'(io_resp.retry));
    fetch_wait();
    io_t(1'b0, 16'h000F, 8'h00);
    chk("mk_data", 32'h0000_0138, 32'({io_resp.claim, io_rdata}));
    io_t(1'b1, 16'h000F, 8'h04);
    chk("all_mask", 32'h3, 32'({mode_mask_wr, mode_mask_val}));
    io_t(1'b1, 16'h000E, 8'hFF);
    chk("clear_mask", 32'h2, 32'({mode_mask_wr, mode_mask_val}));
  endtask : t_group4
  task automatic t_pcpci();
    reg_wr_t(12'h58C, 32'h0000_0201);
    pc_case(32'hC004_0000, 1'b0, 16'h0004, 1'b0, 1'b1);
    pc_case(32'hC004_0000, 1'b0, 16'h0004, 1'b1, 1'b0);
    pc_case(32'hC004_0000, 1'b1, 16'h0000, 1'b0, 1'b1);
    pc_case(32'hC004_0000, 1'b1, 16'h0001, 1'b0, 1'b0);
    pc_case(32'hC004_0000, 1'b0, 16'h1000, 1'b0, 1'b0);
    pc_case(32'hC204_0000, 1'b0, 16'h1000, 1'b0, 1'b1);
    pc_case(32'hC404_0000, 1'b0, 16'h0C00, 1'b0, 1'b1);
    pc_case(32'hC604_0000, 1'b0, 16'h0000, 1'b0, 1'b0);
    pc_case(32'h4004_0000, 1'b0, 16'h0000, 1'b0, 1'b0);
    pc_case(32'h8004_0000, 1'b1, 16'h0000, 1'b0, 1'b0);
    reg_wr_t(12'h58C, 32'h0000_0301);
    pc_case(32'hC004_0000, 1'b0, 16'h0004, 1'b0, 1'b0);
  endtask : t_pcpci
  // ****************************************************************
  // Main sequence and watchdog.
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {reg_wr, reg_rd, global_trap_disable, legacy_audio_mode_bit, engine_mask_bit} = '0;
    pcpci_grant_n = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    io_cyc = '0;
    eng_cur_addr = 16'hB2A1;
    eng_cur_count = 16'h0F3C;
    eng_page = 8'h5E;
    eng_pcpci_data = 8'hD7;
    engine_status_reg = 2'b00;
    lag = 4'h0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_global();
    t_pointer();
    t_group1_write();
    t_group3();
    t_group4();
    t_pcpci();
    close_out();
  end
  // The sequence needs well under 2000 cycles.
  initial begin
    #50000;
    bad_count++;
    close_out();
  end
endmodule : tb
`default_nettype wire

// [src/legacy_io_trap_control.sv]
// Functional notes
// - PC/PCI trap needs grant low.
// - Offset 0 transfer, 4 adds terminal count.
// - PC/PCI reads and writes go to engine.
// - Mask low bits, compare start address.
// - Decode width picks compared bits.
// - Writes trapped only with write enable.
// - Reads trapped only with read enable.
// - Group 1/2 active: snoop 0Ch, clear pointer.
// - Group-1 read trap, toggle on address/count.
// - Group-1 write snoop captures without claiming.
// - Group-2 write snoop offsets 0-7, flip pointer.
// - Group-2 read snoop offsets 0-7, flip pointer.
// - Pointer picks byte; page access never toggles.
// - Group-3 snoops 0Ah/0Bh, forwards matching engine.
// - Status/mask read retried, merged, returned.
// - Retry sequence never blocks other traffic.
// - 0Fh bit of selected engine to mode mask; 0Eh clears.
// - Trapping needs enable set, disable clear.
// - Mode field selects none/grouped/PC-PCI/distributed.
// - Engine select picks engine, default 0.
// - Matching mode write goes to engine mode.
// - Matching single mask bit 2 to control.
`timescale 1ns/1ps
`default_nettype none
`include "legacy_trap_map.svh"
module legacy_io_trap_control (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Host I/O cycles and answers.
  input wire legacy_trap_pkg::io_cycle_t io_cyc,
  input wire logic pcpci_grant_n,
  output legacy_trap_pkg::io_resp_t io_resp,
  output logic [7:0] io_rdata,
  // Loose controls.
  input wire logic global_trap_disable,
  input wire logic legacy_audio_mode_bit,
  // Legacy engine side.
  input wire logic [15:0] eng_cur_addr,
  input wire logic [15:0] eng_cur_count,
  input wire logic [7:0] eng_page,
  input wire logic [7:0] eng_pcpci_data,
  input wire logic [1:0] engine_status_reg,
  input wire logic engine_mask_bit,
  output legacy_trap_pkg::eng_cmd_t eng_cmd,
  output logic ctrl_mask_wr,
  output logic ctrl_mask_val,
  output logic mode_mask_wr,
  output logic mode_mask_val,
  output logic [1:0] legacy_engine_sel,
  output logic legacy_engine_active,
  output logic pcpci_xfer,
  output logic pcpci_tc,
  output logic pcpci_write,
  // Fetch from the real legacy controller.
  output logic fetch_req,
  output logic fetch_is_mask,
  input wire logic fetch_ack,
  input wire logic [7:0] fetch_data
);
  import legacy_trap_pkg::*;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Page location of each legacy engine; the map is not linear.
  function automatic logic [15:0] page_loc(input logic [1:0] sel);
    unique case (sel)
      2'b00: page_loc = `LEG_PAGE0;
      2'b01: page_loc = `LEG_PAGE1;
      2'b10: page_loc = `LEG_PAGE2;
      default: page_loc = `LEG_PAGE3;
    endcase
  endfunction : page_loc

  // Replace one bit of a byte, used for both merges.
  function automatic logic [7:0] merge_bit(input logic [7:0] b, input logic [2:0] idx, input logic v);
    logic [7:0] r;
    r = b;
    r[idx] = v;
    merge_bit = r;
  endfunction : merge_bit

  // Retry sequence states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_READY = 3'b100
  } retry_st_t;

  logic [31:0] pcp_ff, grp_ff, gcr_ff; // Register contents.
  logic [31:0] nxt_pcp, nxt_grp, nxt_gcr;
  logic [31:0] rdata_ff, nxt_rdata; // Register read data.
  io_resp_t resp_ff, nxt_resp; // Host answer.
  logic [7:0] iord_ff, nxt_iord; // Host read data.
  eng_cmd_t cmd_ff, nxt_cmd; // Engine write.
  logic cmw_ff, nxt_cmw, cmv_ff, nxt_cmv; // Control mask write.
  logic mmw_ff, nxt_mmw, mmv_ff, nxt_mmv; // Mode mask write.
  logic pcx_ff, nxt_pcx, pct_ff, nxt_pct, pcw_ff, nxt_pcw; // PC/PCI transfer.
  retry_st_t st_ff, nxt_st; // Retry sequence.
  logic kind_ff, nxt_kind; // Pending read is the mask read.
  logic [7:0] merged_status_store, nxt_status; // Merged status.
  logic [7:0] merged_mask_store, nxt_mask; // Merged mask.

  logic trap_on, grouped, w, range_hit, pc_hit;
  logic [1:0] sel;
  legacy_mode_t mode;
  logic is_addr, is_count, is_page, is_low, c1_loc;
  logic c1_rd, c1_wt, c1_ws, c1_any, c2, bp_toggle, bp_clear;
  logic c3, c3_match, c4w, c4r, byte_pointer_flop;

  // ****************************************************************
  // Cycle decode.
  // ****************************************************************
  trap_range_match u_match (
    .addr(io_cyc.addr),
    .start_addr(pcp_ff[`PCP_SA_HI:0]),
    .low_addr_mask(pcp_ff[`PCP_MSK_HI:`PCP_MSK_LO]),
    .decode_width_sel(pcp_ff[`PCP_DW_HI:`PCP_DW_LO]),
    .hit(range_hit)
  );

  // Classify the present host cycle; everything here is combinational.
  always_comb begin
    trap_on = gcr_ff[`GCR_TRAP_EN] && !global_trap_disable;
    mode = legacy_mode_t'(gcr_ff[`GCR_MODE_HI:`GCR_MODE_LO]);
    sel = gcr_ff[`GCR_ENG_HI:`GCR_ENG_LO];
    byte_pointer_flop = grp_ff[`GRP_BPF];
    w = io_cyc.write;
    grouped = trap_on && (mode == MODE_GROUPED) && io_cyc.valid;
    pc_hit = trap_on && (mode == MODE_PCPCI) && io_cyc.valid && !pcpci_grant_n && range_hit
      && (w ? pcp_ff[`PCP_WE_BIT] : pcp_ff[`PCP_RD_EN_BIT]);
    is_addr = io_cyc.addr == {13'h0000, sel, 1'b0};
    is_count = io_cyc.addr == {13'h0000, sel, 1'b1};
    is_page = io_cyc.addr == page_loc(sel);
    is_low = io_cyc.addr <= `LEG_LOW_TOP;
    c1_loc = is_addr || is_count || is_page;
    c1_rd = grouped && !w && grp_ff[`GRP_G1RE] && c1_loc;
    c1_wt = grouped && w && grp_ff[`GRP_G1WE] && c1_loc;
    // Trap wins if software breaks the exclusion.
    c1_ws = grouped && w && grp_ff[`GRP_G1WS] && !grp_ff[`GRP_G1WE] && c1_loc;
    c1_any = c1_rd || c1_wt || c1_ws;
    c2 = grouped && is_low && !c1_any && (w ? grp_ff[`GRP_G2WS] : grp_ff[`GRP_G2RS]);
    bp_toggle = (c1_any && !is_page) || c2;
    bp_clear = grouped && w && (io_cyc.addr == `LEG_BPF_CLR) && (|grp_ff[`GRP_G1RE:`GRP_G1WS]
      || |grp_ff[`GRP_G2WS:`GRP_G2RS]);
    c3 = grouped && w && grp_ff[`GRP_G3WS] && (io_cyc.addr == `LEG_SMASK || io_cyc.addr == `LEG_MODE);
    c3_match = io_cyc.data[1:0] == sel;
    c4w = grouped && w && grp_ff[`GRP_G4WS] && (io_cyc.addr == `LEG_CLRMASK || io_cyc.addr == `LEG_ALLMASK);
    c4r = grouped && !w && grp_ff[`GRP_G4RE] && (io_cyc.addr == `LEG_STATUS || io_cyc.addr == `LEG_ALLMASK);
  end

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // The retry sequence runs beside the other decode paths, so transfers
  // and snoops keep flowing while a status read is pending.
  always_comb begin
    nxt_pcp = pcp_ff;
    nxt_grp = grp_ff;
    nxt_gcr = gcr_ff;
    nxt_rdata = rdata_ff;
    nxt_resp = '0;
    nxt_iord = iord_ff;
    nxt_cmd = '0;
    nxt_cmw = 1'b0;
    nxt_cmv = cmv_ff;
    nxt_mmw = 1'b0;
    nxt_mmv = mmv_ff;
    nxt_pcx = pc_hit;
    nxt_pct = pc_hit ? io_cyc.addr[`PCP_TC_BIT] : pct_ff;
    nxt_pcw = pc_hit ? w : pcw_ff;
    nxt_st = st_ff;
    nxt_kind = kind_ff;
    nxt_status = merged_status_store;
    nxt_mask = merged_mask_store;
    // Software writes; hardware pointer events below take priority.
    if (reg_wr) begin
      if (reg_addr == `OFS_PCPCI_TRAP) nxt_pcp = reg_wdata & `PCP_WMASK;
      if (reg_addr == `OFS_GROUP_CTRL) nxt_grp = reg_wdata & `GRP_WMASK;
      if (reg_addr == `OFS_GLOBAL_CTRL) nxt_gcr = reg_wdata & `GCR_WMASK;
    end
    if (bp_clear) begin
      nxt_grp[`GRP_BPF] = 1'b0;
    end else if (bp_toggle) begin
      nxt_grp[`GRP_BPF] = !byte_pointer_flop;
    end
    // Register reads; unmapped offsets read zero.
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_PCPCI_TRAP: nxt_rdata = pcp_ff;
        `OFS_GROUP_CTRL: nxt_rdata = grp_ff;
        `OFS_GLOBAL_CTRL: nxt_rdata = gcr_ff;
        default: nxt_rdata = `REG_RST;
      endcase
    end
    // Claims and snoops.
    nxt_resp.claim = pc_hit || c1_rd || c1_wt;
    nxt_resp.snoop = c1_ws || c2 || bp_clear || c3 || c4w;
    if (pc_hit && !w) nxt_iord = eng_pcpci_data;
    if (c1_rd) begin
      // Pointer picks the byte of address and count reads.
      if (is_page) nxt_iord = eng_page;
      else if (is_addr) nxt_iord = byte_pointer_flop ? eng_cur_addr[15:8] : eng_cur_addr[7:0];
      else nxt_iord = byte_pointer_flop ? eng_cur_count[15:8] : eng_cur_count[7:0];
    end
    if (c1_wt || c1_ws) begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.field = is_page ? FLD_PAGE : (is_addr ? FLD_ADDR : FLD_COUNT);
      nxt_cmd.hi = byte_pointer_flop;
      nxt_cmd.data = io_cyc.data;
    end
    if (c3 && c3_match) begin
      if (io_cyc.addr == `LEG_MODE) begin
        nxt_cmd.valid = 1'b1;
        nxt_cmd.field = FLD_MODE;
        nxt_cmd.data = io_cyc.data;
      end else begin
        nxt_cmw = 1'b1;
        nxt_cmv = io_cyc.data[2];
      end
    end
    if (c4w) begin
      nxt_mmw = 1'b1;
      nxt_mmv = (io_cyc.addr == `LEG_ALLMASK) ? io_cyc.data[sel] : 1'b0;
    end
    // Status and all-mask reads: retry, fetch and merge, then answer.
    unique case (st_ff)
      ST_IDLE: begin
        if (c4r) begin
          nxt_resp.retry = 1'b1;
          nxt_kind = io_cyc.addr == `LEG_ALLMASK;
          nxt_st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        nxt_resp.retry = c4r;
        if (fetch_ack) begin
          nxt_status = merge_bit(merge_bit(fetch_data, {1'b0, sel}, engine_status_reg[0]),
            `STATUS_REQ_OFS + {1'b0, sel}, engine_status_reg[1]);
          nxt_mask = merge_bit(fetch_data, {1'b0, sel}, engine_mask_bit);
          nxt_st = ST_READY;
        end
      end
      ST_READY: begin
        if (c4r && ((io_cyc.addr == `LEG_ALLMASK) == kind_ff)) begin
          nxt_resp.claim = 1'b1;
          nxt_iord = kind_ff ? merged_mask_store : merged_status_store;
          nxt_st = ST_IDLE;
        end else begin
          nxt_resp.retry = c4r;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // State registers.
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcp_ff <= `REG_RST;
      grp_ff <= `REG_RST;
      gcr_ff <= `REG_RST;
      rdata_ff <= `REG_RST;
      resp_ff <= '0;
      iord_ff <= 8'h00;
      cmd_ff <= '0;
      cmw_ff <= 1'b0;
      cmv_ff <= 1'b0;
      mmw_ff <= 1'b0;
      mmv_ff <= 1'b0;
      pcx_ff <= 1'b0;
      pct_ff <= 1'b0;
      pcw_ff <= 1'b0;
      st_ff <= ST_IDLE;
      kind_ff <= 1'b0;
      merged_status_store <= 8'h00;
      merged_mask_store <= 8'h00;
    end else begin
      pcp_ff <= nxt_pcp;
      grp_ff <= nxt_grp;
      gcr_ff <= nxt_gcr;
      rdata_ff <= nxt_rdata;
      resp_ff <= nxt_resp;
      iord_ff <= nxt_iord;
      cmd_ff <= nxt_cmd;
      cmw_ff <= nxt_cmw;
      cmv_ff <= nxt_cmv;
      mmw_ff <= nxt_mmw;
      mmv_ff <= nxt_mmv;
      pcx_ff <= nxt_pcx;
      pct_ff <= nxt_pct;
      pcw_ff <= nxt_pcw;
      st_ff <= nxt_st;
      kind_ff <= nxt_kind;
      merged_status_store <= nxt_status;
      merged_mask_store <= nxt_mask;
    end
  end

  // Outputs.
  assign reg_rdata = rdata_ff;
  assign io_resp = resp_ff;
  assign io_rdata = iord_ff;
  assign eng_cmd = cmd_ff;
  assign ctrl_mask_wr = cmw_ff;
  assign ctrl_mask_val = cmv_ff;
  assign mode_mask_wr = mmw_ff;
  assign mode_mask_val = mmv_ff;
  assign pcpci_xfer = pcx_ff;
  assign pcpci_tc = pct_ff;
  assign pcpci_write = pcw_ff;
  assign legacy_engine_sel = sel;
  assign legacy_engine_active = (trap_on && mode == MODE_GROUPED) || legacy_audio_mode_bit;
  assign fetch_req = st_ff == ST_FETCH;
  assign fetch_is_mask = kind_ff;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_GRANT: assert property (pcpci_xfer |-> $past(!pcpci_grant_n)) else $error("transfer without grant");
  AST_TC: assert property (pcpci_xfer |-> pcpci_tc == $past(io_cyc.addr[`PCP_TC_BIT])) else $error("bad tc");
  AST_DIR: assert property (pcpci_xfer |-> pcpci_write == $past(io_cyc.write)) else $error("bad dir");
  AST_WE: assert property (pcpci_xfer && pcpci_write |-> $past(pcp_ff[`PCP_WE_BIT])) else $error("write no en");
  AST_RE: assert property (pcpci_xfer && !pcpci_write |-> $past(pcp_ff[`PCP_RD_EN_BIT])) else $error("read no en");
  AST_CLR: assert property (bp_clear |=> !grp_ff[`GRP_BPF]) else $error("pointer not cleared");
  AST_TGL: assert property (bp_toggle && !bp_clear |=> grp_ff[`GRP_BPF] != $past(grp_ff[`GRP_BPF]))
    else $error("no flip");
  AST_PAGE: assert property (grouped && is_page && !reg_wr |=> $stable(grp_ff[`GRP_BPF])) else $error("page flip");
  AST_OFF: assert property (!trap_on |=> !io_resp.claim && !io_resp.snoop) else $error("trap while off");
  AST_RETRY: assert property (c4r && st_ff == ST_IDLE |=> io_resp.retry && fetch_req) else $error("no retry");
  AST_MODE: assert property (eng_cmd.valid && eng_cmd.field == FLD_MODE |-> $past(io_cyc.data[1:0]) == sel)
    else $error("mode for other engine");
endmodule : legacy_io_trap_control
`default_nettype wire

// [src/legacy_trap_map.svh]
`ifndef LEGACY_TRAP_MAP_SVH
`define LEGACY_TRAP_MAP_SVH
// ****************************************************************
// Register offsets and write masks.
// ****************************************************************
`define OFS_PCPCI_TRAP 12'h52C
`define OFS_GROUP_CTRL 12'h530
`define OFS_GLOBAL_CTRL 12'h58C
`define REG_RST 32'h0000_0000
`define PCP_WMASK 32'hC607_FFFF
`define GRP_WMASK 32'hE1F1_0000
`define GCR_WMASK 32'h0000_0F01
// ****************************************************************
// Field positions.
// ****************************************************************
`define PCP_RD_EN_BIT 31
`define PCP_WE_BIT 30
`define PCP_DW_HI 26
`define PCP_DW_LO 25
`define PCP_MSK_HI 18
`define PCP_MSK_LO 16
`define PCP_SA_HI 15
`define PCP_TC_BIT 2
`define GRP_G1RE 31
`define GRP_G1WE 30
`define GRP_G1WS 29
`define GRP_G3WS 24
`define GRP_G4RE 23
`define GRP_G4WS 22
`define GRP_G2WS 21
`define GRP_G2RS 20
`define GRP_BPF 16
`define GCR_TRAP_EN 0
`define GCR_MODE_HI 9
`define GCR_MODE_LO 8
`define GCR_ENG_HI 11
`define GCR_ENG_LO 10
// ****************************************************************
// Decode widths and legacy locations.
// ****************************************************************
`define DW_FULL 2'b00
`define DW_12 2'b01
`define DW_10 2'b10
`define DW_FULL_KEEP 16'hFFFF
`define DW_12_KEEP 16'h0FFF
`define DW_10_KEEP 16'h03FF
`define LEG_STATUS 16'h0008
`define LEG_SMASK 16'h000A
`define LEG_MODE 16'h000B
`define LEG_BPF_CLR 16'h000C
`define LEG_CLRMASK 16'h000E
`define LEG_ALLMASK 16'h000F
`define LEG_LOW_TOP 16'h0007
`define LEG_PAGE0 16'h0087
`define LEG_PAGE1 16'h0083
`define LEG_PAGE2 16'h0081
`define LEG_PAGE3 16'h0082
`define STATUS_REQ_OFS 3'h4
`endif

// [src/legacy_trap_pkg.sv]
package legacy_trap_pkg;
  // Legacy DMA support mode.
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_GROUPED = 2'b01,
    MODE_PCPCI = 2'b10,
    MODE_DISTRIBUTED = 2'b11
  } legacy_mode_t;
  // Engine register targeted by a redirected write.
  typedef enum logic [1:0] {
    FLD_ADDR = 2'b00,
    FLD_COUNT = 2'b01,
    FLD_PAGE = 2'b10,
    FLD_MODE = 2'b11
  } eng_field_t;
  // One host I/O cycle as seen on the PCI side.
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } io_cycle_t;
  // Answer to a host I/O cycle.
  typedef struct packed {
    logic claim;
    logic snoop;
    logic retry;
  } io_resp_t;
  // Write into the legacy engine's registers.
  typedef struct packed {
    logic valid;
    eng_field_t field;
    logic hi;
    logic [7:0] data;
  } eng_cmd_t;
endpackage : legacy_trap_pkg

// [src/trap_range_match.sv]
`timescale 1ns/1ps
`default_nettype none
`include "legacy_trap_map.svh"
module trap_range_match (
  // Cycle address.
  input wire logic [15:0] addr,
  // Range setup.
  input wire logic [15:0] start_addr,
  input wire logic [2:0] low_addr_mask,
  input wire logic [1:0] decode_width_sel,
  // Result.
  output logic hit
);
  logic [15:0] keep;
  logic [15:0] masked;
  // ****************************************************************
  // Masked compare against the start address.
  // ****************************************************************
  // Upper bits outside the decode width alias; the reserved width never hits.
  always_comb begin
    unique case (decode_width_sel)
      `DW_FULL: keep = `DW_FULL_KEEP;
      `DW_12: keep = `DW_12_KEEP;
      default: keep = `DW_10_KEEP;
    endcase
    masked = addr & ~{13'h0000, low_addr_mask};
    hit = ((masked & keep) == (start_addr & keep)) && (decode_width_sel != 2'b11);
  end
endmodule : trap_range_match
`default_nettype wire
